// file: logic/pfsm_cfg.svh
`ifndef PFSM_CFG_SVH
`define PFSM_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define PFSM_IDX_P0_MASK  16'h5205
`define PFSM_IDX_P0_FLAG  16'h5207
`define PFSM_IDX_P0_CHAT  16'h5208
`define PFSM_IDX_KRST     16'h5209
`define PFSM_IDX_P1_MASK  16'h5215
`define PFSM_IDX_P1_FLAG  16'h5217
`define PFSM_IDX_P1_CHAT  16'h5218
`define PFSM_IDX_P0_SEL   16'h52A0
`define PFSM_IDX_P1_SEL   16'h52A1
`define PFSM_IDX_P2_SEL   16'h52A2
`define PFSM_IDX_P3_SEL   16'h52A3
`define PFSM_IDX_HI_ZERO  14'h0000

// Writable bits of the port 0 and port 3 select registers and the reset value.
`define PFSM_P0_SEL_BITS  8'h3C
`define PFSM_P3_SEL_BITS  8'h0F
`define PFSM_SEL_RESET    8'h00
`define PFSM_P3_DBG_BITS  8'h0E
`define PFSM_BYTE_ZERO    8'h00
`define PFSM_BYTE_ONES    8'hFF

// Timer 0 external clock shares port 1 pin 6.
`define PFSM_EXCL_PORT    1
`define PFSM_EXCL_BIT     6

// Chattering filter: code 0 is off, code n gives 256 << (n-1) ticks.
`define PFSM_CHAT_OFF     3'h0
`define PFSM_CHAT_BASE    15'h0100
`define PFSM_CHAT_ONE     3'h1
`define PFSM_CNT_ZERO     15'h0000
`define PFSM_CNT_ONE      15'h0001

// Key-entry reset pin choice codes.
`define PFSM_KRST_OFF     2'h0
`define PFSM_KRST_P01     2'h1
`define PFSM_KRST_P02     2'h2
`define PFSM_KRST_P03     2'h3

`define PFSM_RESP_OKAY    2'h0
`define PFSM_RESP_SLVERR  2'h2
`define PFSM_WORD_ZERO    32'h00000000

`endif

// file: logic/pfsm_debounce.sv
`timescale 1ns/100ps
`include "pfsm_cfg.svh"
module pfsm_debounce (
	input  wire logic aclk,    // Peripheral clock.
	input  wire logic aresetn, // Synchronous reset, active low.
	pfsm_flt_if.flt   f        // Filter configuration and pin.
);
	logic [14:0] cnt_reg;
	logic [14:0] limit;
	logic        clean_reg;

	assign limit = `PFSM_CHAT_BASE << (f.check_code - `PFSM_CHAT_ONE);
	assign f.clean = clean_reg;

	// With the filter on, a change is taken only after the pin held its new level for a full check time.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clean_reg <= 1'b1;
			cnt_reg   <= `PFSM_CNT_ZERO;
		end else if (f.check_code == `PFSM_CHAT_OFF) begin
			clean_reg <= f.raw;
			cnt_reg   <= `PFSM_CNT_ZERO;
		end else if (f.raw == clean_reg) begin
			cnt_reg <= `PFSM_CNT_ZERO;
		end else if (f.tick) begin
			if (cnt_reg + `PFSM_CNT_ONE >= limit) begin
				clean_reg <= f.raw;
				cnt_reg   <= `PFSM_CNT_ZERO;
			end else begin
				cnt_reg <= cnt_reg + `PFSM_CNT_ONE;
			end
		end
	end

	property p_no_tick_hold;
		@(posedge aclk) disable iff (!aresetn)
		(f.check_code != `PFSM_CHAT_OFF && !f.tick && $stable(f.check_code))
			|=> $stable(clean_reg);
	endproperty
	a_no_tick_hold: assert property (p_no_tick_hold) else $error("filter moved without tick");
endmodule : pfsm_debounce

// file: logic/pfsm_flt_if.sv
`timescale 1ns/100ps
interface pfsm_flt_if;
	pfsm_pkg::pfsm_chat_t check_code;
	logic                 tick;
	logic                 raw;
	logic                 clean;
	modport ctl (output check_code, output tick, output raw, input clean);
	modport flt (input check_code, input tick, input raw, output clean);
endinterface : pfsm_flt_if

// file: logic/pfsm_keyrst.sv
`timescale 1ns/100ps
`include "pfsm_cfg.svh"
module pfsm_keyrst (
	input  wire logic                 aclk,      // Peripheral clock.
	input  wire logic                 aresetn,   // Synchronous reset, active low.
	input  wire pfsm_pkg::pfsm_krst_t choice,    // Key reset pin choice.
	input  wire logic [3:0]           pins,      // Port 0 pins 3 to 0.
	input  wire logic                 sleep,     // Chip is in sleep.
	output logic                      reset_req  // Request for an initial reset.
);
	logic hit;

	always_comb begin
		case (choice)
			`PFSM_KRST_P03: hit = (pins[3:0] == 4'h0);
			`PFSM_KRST_P02: hit = (pins[2:0] == 3'h0);
			`PFSM_KRST_P01: hit = (pins[1:0] == 2'h0);
			default:        hit = 1'b0;
		endcase
	end

	// Reset clears the choice upstream, so nothing fires at power-on.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_req <= 1'b0;
		end else begin
			reset_req <= hit && !sleep;
		end
	end

	property p_sleep_blocks;
		@(posedge aclk) disable iff (!aresetn) sleep |=> !reset_req;
	endproperty
	a_sleep_blocks: assert property (p_sleep_blocks) else $error("key reset in sleep");

	property p_all_low;
		@(posedge aclk) disable iff (!aresetn)
		(choice == `PFSM_KRST_P03 && pins == 4'h0 && !sleep) |=> reset_req;
	endproperty
	a_all_low: assert property (p_all_low) else $error("key reset missed");
endmodule : pfsm_keyrst

// file: logic/pfsm_pkg.sv
package pfsm_pkg;
	typedef logic [7:0] pfsm_byte_t;
	typedef logic [2:0] pfsm_chat_t;
	typedef logic [1:0] pfsm_krst_t;
	typedef enum logic [1:0] {
		PFSM_RD_IDLE = 2'b01,
		PFSM_RD_DATA = 2'b10
	} pfsm_rd_state_t;
endpackage : pfsm_pkg

// file: logic/pfsm_top.sv
// Operation
// - Port 0 bits 5,4 route extended timer 1 inverted and true outputs.
// - Port 0 bits 3,2 route remote controller out and in; others reserved.
// - Port 1 select has eight read/write bits, zero after reset.
// - Port 1 bit 6 drives low-speed timer; clear feeds timer 0 clock.
// - Port 2 bits 7..3 route extended timer 0 and UART 0 signals.
// - Port 2 bits 2,1,0 route SPI clock, data out and data in.
// - Port 3 bits 3..1 inverted: zero selects debug signals; upper reserved.
// - Port 3 bit 0 drives high oscillator clock output; reset clear.
// - With filter on, sleep blocks input interrupts; turn filter off first.
// - Filter rejects pulses shorter than check time; accepts within two.
// - Key reset disabled by initial reset and inoperative in sleep.
// - All chosen port 0 pins low together request an initial reset.
// - Check time code 1..7 gives 256..16384 ticks; 0 is off.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "pfsm_cfg.svh"
module pfsm_top (
	input  wire logic             aclk,                // Peripheral clock, 100 MHz.
	input  wire logic             aresetn,             // Synchronous reset, active low.
	input  wire logic [31:0]      s_axi_awaddr,        // Write address.
	input  wire logic [2:0]       s_axi_awprot,        // Unused protection.
	input  wire logic             s_axi_awvalid,       // Write address valid.
	output logic                  s_axi_awready,       // Write address ready.
	input  wire logic [31:0]      s_axi_wdata,         // Write data.
	input  wire logic [3:0]       s_axi_wstrb,         // Write strobes.
	input  wire logic             s_axi_wvalid,        // Write data valid.
	output logic                  s_axi_wready,        // Write data ready.
	output logic [1:0]            s_axi_bresp,         // Write response.
	output logic                  s_axi_bvalid,        // Write response valid.
	input  wire logic             s_axi_bready,        // Write response ready.
	input  wire logic [31:0]      s_axi_araddr,        // Read address.
	input  wire logic [2:0]       s_axi_arprot,        // Unused protection.
	input  wire logic             s_axi_arvalid,       // Read address valid.
	output logic                  s_axi_arready,       // Read address ready.
	output logic [31:0]           s_axi_rdata,         // Read data.
	output logic [1:0]            s_axi_rresp,         // Read response.
	output logic                  s_axi_rvalid,        // Read data valid.
	input  wire logic             s_axi_rready,        // Read data ready.
	input  wire logic [3:0][7:0]  pin_in,              // Pin levels, port by pin.
	input  wire logic [3:0][7:0]  gpio_out,            // General port output values.
	input  wire logic [3:0][7:0]  gpio_oe,             // General port output enables.
	input  wire logic [3:0][7:0]  periph_out,          // Peripheral output, pin position.
	input  wire logic [3:0][7:0]  periph_oe,           // Peripheral output enable.
	input  wire logic             prescaler_tick,      // One pulse per prescaler period.
	input  wire logic             sleep_mode,          // Chip is in sleep.
	output logic [3:0][7:0]       pin_out,             // Pin output value.
	output logic [3:0][7:0]       pin_oe,              // Pin output enable, high drives.
	output logic [3:0][7:0]       gpio_in,             // Pin level to general ports.
	output logic [3:0][7:0]       periph_in,           // Pin level to peripherals.
	output logic                  timer0_ext_clock_in, // Timer 0 external clock.
	output logic                  port0_irq,           // Port 0 interrupt request.
	output logic                  port1_irq,           // Port 1 interrupt request.
	output logic                  key_reset_req        // Initial reset request.
);
	pfsm_pkg::pfsm_byte_t       sel_reg [4];
	pfsm_pkg::pfsm_byte_t       mask_reg [2];
	pfsm_pkg::pfsm_byte_t       flag_reg [2];
	pfsm_pkg::pfsm_byte_t       clean_prev_reg [2];
	pfsm_pkg::pfsm_chat_t       chat_reg [2];
	pfsm_pkg::pfsm_krst_t       krst_reg;
	pfsm_pkg::pfsm_rd_state_t   rd_state_reg;
	logic [3:0][7:0]            eff_sel;
	logic [1:0][7:0]            clean;
	logic [1:0][7:0]            flag_set;
	logic [1:0]                 flt_on;
	logic                       aw_held_reg;
	logic                       w_held_reg;
	logic [31:0]                awaddr_reg;
	logic [7:0]                 wdata_reg;
	logic                       wstrb0_reg;
	logic                       wr_go;
	logic                       wr_hit;
	logic [31:0]                rd_word;
	logic                       rd_hit;

	// A bus address matches a register index when the high bits and the two low bits are zero.
	function automatic logic addr_is(input logic [31:0] a, input logic [15:0] idx);
		addr_is = (a == {`PFSM_IDX_HI_ZERO, idx, 2'b00});
	endfunction : addr_is

	// Port 3 select is inverted on the debug pins, so those bits flip here.
	always_comb begin
		eff_sel[0] = sel_reg[0] & `PFSM_P0_SEL_BITS;
		eff_sel[1] = sel_reg[1];
		eff_sel[2] = sel_reg[2];
		eff_sel[3] = (sel_reg[3] ^ `PFSM_P3_DBG_BITS) & `PFSM_P3_SEL_BITS;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out   <= '0;
			pin_oe    <= '0;
			gpio_in   <= '0;
			periph_in <= '0;
		end else begin
			for (int p = 0; p < 4; p++) begin
				pin_out[p]   <= (eff_sel[p] & periph_out[p]) | (~eff_sel[p] & gpio_out[p]);
				pin_oe[p]    <= (eff_sel[p] & periph_oe[p]) | (~eff_sel[p] & gpio_oe[p]);
				gpio_in[p]   <= pin_in[p] & ~eff_sel[p];
				periph_in[p] <= pin_in[p] & eff_sel[p];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer0_ext_clock_in <= 1'b0;
		end else begin
			timer0_ext_clock_in <= pin_in[`PFSM_EXCL_PORT][`PFSM_EXCL_BIT]
				& ~eff_sel[`PFSM_EXCL_PORT][`PFSM_EXCL_BIT];
		end
	end

	// Chattering filters on ports 0 and 1; they feed the interrupt flags only.
	genvar gp;
	genvar gi;
	generate
		for (gp = 0; gp < 2; gp++) begin : g_port
			for (gi = 0; gi < 8; gi++) begin : g_pin
				pfsm_flt_if flt ();
				assign flt.check_code = chat_reg[gp];
				assign flt.tick       = prescaler_tick;
				assign flt.raw        = pin_in[gp][gi];
				assign clean[gp][gi]  = flt.clean;
				pfsm_debounce u_flt (
					.aclk    (aclk),
					.aresetn (aresetn),
					.f       (flt.flt)
				);
			end
		end
	endgenerate

	// Interrupts are refused during sleep with the filter on, although the filter keeps settling on prescaler ticks.
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			flt_on[p]   = (chat_reg[p] != `PFSM_CHAT_OFF);
			flag_set[p] = (sleep_mode && flt_on[p]) ? `PFSM_BYTE_ZERO
				: (clean[p] ^ clean_prev_reg[p]);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clean_prev_reg[0] <= `PFSM_BYTE_ONES;
			clean_prev_reg[1] <= `PFSM_BYTE_ONES;
		end else begin
			clean_prev_reg[0] <= clean[0];
			clean_prev_reg[1] <= clean[1];
		end
	end

	// Flags are write-one-to-clear; a new event in the clearing cycle wins.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_reg[0] <= `PFSM_BYTE_ZERO;
			flag_reg[1] <= `PFSM_BYTE_ZERO;
		end else begin
			flag_reg[0] <= (flag_reg[0] & ~((wr_go && addr_is(awaddr_reg, `PFSM_IDX_P0_FLAG))
				? wdata_reg : `PFSM_BYTE_ZERO)) | flag_set[0];
			flag_reg[1] <= (flag_reg[1] & ~((wr_go && addr_is(awaddr_reg, `PFSM_IDX_P1_FLAG))
				? wdata_reg : `PFSM_BYTE_ZERO)) | flag_set[1];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port0_irq <= 1'b0;
			port1_irq <= 1'b0;
		end else begin
			port0_irq <= |(flag_reg[0] & mask_reg[0]);
			port1_irq <= |(flag_reg[1] & mask_reg[1]);
		end
	end

	pfsm_keyrst u_krst (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.choice    (krst_reg),
		.pins      (pin_in[0][3:0]),
		.sleep     (sleep_mode),
		.reset_req (key_reset_req)
	);

	// Write channel: address and data are taken independently, one write at a time.
	assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PFSM_RESP_OKAY;
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			awaddr_reg    <= `PFSM_WORD_ZERO;
			wdata_reg     <= `PFSM_BYTE_ZERO;
			wstrb0_reg    <= 1'b0;
		end else begin
			if (!aw_held_reg && !s_axi_bvalid) begin
				s_axi_awready <= !(s_axi_awvalid && s_axi_awready);
			end
			if (!w_held_reg && !s_axi_bvalid) begin
				s_axi_wready <= !(s_axi_wvalid && s_axi_wready);
			end
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `PFSM_RESP_OKAY : `PFSM_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign wr_hit = addr_is(awaddr_reg, `PFSM_IDX_P0_SEL) || addr_is(awaddr_reg, `PFSM_IDX_P1_SEL)
		|| addr_is(awaddr_reg, `PFSM_IDX_P2_SEL) || addr_is(awaddr_reg, `PFSM_IDX_P3_SEL)
		|| addr_is(awaddr_reg, `PFSM_IDX_P0_MASK) || addr_is(awaddr_reg, `PFSM_IDX_P1_MASK)
		|| addr_is(awaddr_reg, `PFSM_IDX_P0_FLAG) || addr_is(awaddr_reg, `PFSM_IDX_P1_FLAG)
		|| addr_is(awaddr_reg, `PFSM_IDX_P0_CHAT) || addr_is(awaddr_reg, `PFSM_IDX_P1_CHAT)
		|| addr_is(awaddr_reg, `PFSM_IDX_KRST);

	// Only byte lane 0 carries register bits; a write without it still clears flags but changes no other register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int p = 0; p < 4; p++) begin
				sel_reg[p] <= `PFSM_SEL_RESET;
			end
		end else if (wr_go && wstrb0_reg) begin
			if (addr_is(awaddr_reg, `PFSM_IDX_P0_SEL)) begin
				sel_reg[0] <= wdata_reg & `PFSM_P0_SEL_BITS;
			end else if (addr_is(awaddr_reg, `PFSM_IDX_P1_SEL)) begin
				sel_reg[1] <= wdata_reg;
			end else if (addr_is(awaddr_reg, `PFSM_IDX_P2_SEL)) begin
				sel_reg[2] <= wdata_reg;
			end else if (addr_is(awaddr_reg, `PFSM_IDX_P3_SEL)) begin
				sel_reg[3] <= wdata_reg & `PFSM_P3_SEL_BITS;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_reg[0] <= `PFSM_BYTE_ZERO;
			mask_reg[1] <= `PFSM_BYTE_ZERO;
			chat_reg[0] <= `PFSM_CHAT_OFF;
			chat_reg[1] <= `PFSM_CHAT_OFF;
			krst_reg    <= `PFSM_KRST_OFF;
		end else if (wr_go && wstrb0_reg) begin
			if (addr_is(awaddr_reg, `PFSM_IDX_P0_MASK)) begin
				mask_reg[0] <= wdata_reg;
			end else if (addr_is(awaddr_reg, `PFSM_IDX_P1_MASK)) begin
				mask_reg[1] <= wdata_reg;
			end else if (addr_is(awaddr_reg, `PFSM_IDX_P0_CHAT)) begin
				chat_reg[0] <= wdata_reg[2:0];
			end else if (addr_is(awaddr_reg, `PFSM_IDX_P1_CHAT)) begin
				chat_reg[1] <= wdata_reg[2:0];
			end else if (addr_is(awaddr_reg, `PFSM_IDX_KRST)) begin
				krst_reg <= wdata_reg[1:0];
			end
		end
	end

	always_comb begin
		rd_hit  = 1'b1;
		rd_word = `PFSM_WORD_ZERO;
		if (addr_is(s_axi_araddr, `PFSM_IDX_P0_SEL)) begin
			rd_word[7:0] = sel_reg[0];
		end else if (addr_is(s_axi_araddr, `PFSM_IDX_P1_SEL)) begin
			rd_word[7:0] = sel_reg[1];
		end else if (addr_is(s_axi_araddr, `PFSM_IDX_P2_SEL)) begin
			rd_word[7:0] = sel_reg[2];
		end else if (addr_is(s_axi_araddr, `PFSM_IDX_P3_SEL)) begin
			rd_word[7:0] = sel_reg[3];
		end else if (addr_is(s_axi_araddr, `PFSM_IDX_P0_MASK)) begin
			rd_word[7:0] = mask_reg[0];
		end else if (addr_is(s_axi_araddr, `PFSM_IDX_P1_MASK)) begin
			rd_word[7:0] = mask_reg[1];
		end else if (addr_is(s_axi_araddr, `PFSM_IDX_P0_FLAG)) begin
			rd_word[7:0] = flag_reg[0];
		end else if (addr_is(s_axi_araddr, `PFSM_IDX_P1_FLAG)) begin
			rd_word[7:0] = flag_reg[1];
		end else if (addr_is(s_axi_araddr, `PFSM_IDX_P0_CHAT)) begin
			rd_word[2:0] = chat_reg[0];
		end else if (addr_is(s_axi_araddr, `PFSM_IDX_P1_CHAT)) begin
			rd_word[2:0] = chat_reg[1];
		end else if (addr_is(s_axi_araddr, `PFSM_IDX_KRST)) begin
			rd_word[1:0] = krst_reg;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_reg  <= pfsm_pkg::PFSM_RD_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= `PFSM_WORD_ZERO;
			s_axi_rresp   <= `PFSM_RESP_OKAY;
		end else begin
			case (rd_state_reg)
				pfsm_pkg::PFSM_RD_IDLE: begin
					s_axi_arready <= 1'b1;
					if (s_axi_arvalid && s_axi_arready) begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid  <= 1'b1;
						s_axi_rdata   <= rd_word;
						s_axi_rresp   <= rd_hit ? `PFSM_RESP_OKAY : `PFSM_RESP_SLVERR;
						rd_state_reg  <= pfsm_pkg::PFSM_RD_DATA;
					end
				end
				pfsm_pkg::PFSM_RD_DATA: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_state_reg <= pfsm_pkg::PFSM_RD_IDLE;
					end
				end
				default: rd_state_reg <= pfsm_pkg::PFSM_RD_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_p0_timer;
		sel_reg[0][5] |=> pin_out[0][5] == $past(periph_out[0][5]);
	endproperty
	a_p0_timer: assert property (p_p0_timer) else $error("port 0 pin 5 not timer");

	property p_p0_reserved;
		(sel_reg[0] & ~`PFSM_P0_SEL_BITS) == `PFSM_BYTE_ZERO;
	endproperty
	a_p0_reserved: assert property (p_p0_reserved) else $error("port 0 reserved bit set");

	property p_p1_reset;
		$past(!aresetn) |-> sel_reg[1] == `PFSM_SEL_RESET && sel_reg[3] == `PFSM_SEL_RESET;
	endproperty
	a_p1_reset: assert property (p_p1_reset) else $error("select not cleared by reset");

	property p_excl;
		!sel_reg[1][6] |=> timer0_ext_clock_in == $past(pin_in[1][6]);
	endproperty
	a_excl: assert property (p_excl) else $error("timer 0 clock not fed");

	property p_dbg;
		!sel_reg[3][1] |=> pin_oe[3][1] == $past(periph_oe[3][1]);
	endproperty
	a_dbg: assert property (p_dbg) else $error("debug clock not routed");

	property p_gpio;
		!sel_reg[2][0] |=> pin_out[2][0] == $past(gpio_out[2][0]) && !periph_in[2][0];
	endproperty
	a_gpio: assert property (p_gpio) else $error("general port lost pin");

	property p_sleep_flags;
		(sleep_mode && chat_reg[0] != `PFSM_CHAT_OFF)
			|=> (flag_reg[0] & ~$past(flag_reg[0])) == `PFSM_BYTE_ZERO;
	endproperty
	a_sleep_flags: assert property (p_sleep_flags) else $error("flag set in sleep");

	sequence s_wr_taken;
		aw_held_reg && w_held_reg && !s_axi_bvalid;
	endsequence
	property p_wr_resp;
		s_wr_taken |=> s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("no write response");
endmodule : pfsm_top

// file: test/pfsm_periph_model.sv
`timescale 1ns/100ps
module pfsm_periph_model (
	input  wire logic       aclk,          // Peripheral clock.
	input  wire logic       aresetn,       // Synchronous reset, active low.
	output logic [3:0][7:0] periph_out,    // Peripheral drive.
	output logic [3:0][7:0] periph_oe,     // Peripheral enables.
	output logic            prescaler_tick // Filter time base.
);
	logic [1:0] div_reg;
	// Complement of the general drive, so every misrouted bit shows.
	assign periph_out = {4{8'h5A}};
	assign periph_oe  = {4{8'hF0}};
	always_ff @(posedge aclk) begin
		if (!aresetn) div_reg <= 2'h0;
		else div_reg <= div_reg + 2'h1;
	end
	assign prescaler_tick = (div_reg == 2'h3);
endmodule : pfsm_periph_model

// file: test/pfsm_tb_top.sv
`timescale 1ns/100ps
`include "pfsm_cfg.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module pfsm_tb_top;
	logic            aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_mode;
	logic            awready, wready, bvalid, arready, rvalid, tick, p0_irq, p1_irq;
	logic            krst_req, t0_clk;
	logic [31:0]     awaddr, wdata, araddr, rdata, rd_data;
	logic [3:0]      wstrb;
	logic [1:0]      bresp, rresp, resp;
	logic [3:0][7:0] pin_in, pin_out, pin_oe, gpio_in, periph_in, p_out, p_oe;
	logic [7:0]      w, es, pm;
	logic [7:0]      mask [4];
	int              failures, check_count, cyc;
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	pfsm_periph_model PM (.aclk(aclk), .aresetn(aresetn), .periph_out(p_out),
		.periph_oe(p_oe), .prescaler_tick(tick));
	pfsm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
		.gpio_out({4{8'hA5}}), .gpio_oe({4{8'h0F}}), .periph_out(p_out), .periph_oe(p_oe),
		.prescaler_tick(tick), .sleep_mode(sleep_mode), .pin_out(pin_out), .pin_oe(pin_oe),
		.gpio_in(gpio_in), .periph_in(periph_in), .timer0_ext_clock_in(t0_clk),
		.port0_irq(p0_irq), .port1_irq(p1_irq), .key_reset_req(krst_req));
	task results;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	task wr(input logic [15:0] idx, input logic [7:0] d);
		awaddr <= {`PFSM_IDX_HI_ZERO, idx, 2'b00};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		resp = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task rd(input logic [15:0] idx);
		araddr <= {`PFSM_IDX_HI_ZERO, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		rd_data = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	function automatic logic [7:0] mx(input logic [7:0] s, g, p);
		return (s & p) | (~s & g);
	endfunction : mx
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			results();
		end
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_mode} = 7'h00;
		{awaddr, wdata, araddr} = '0;
		wstrb = 4'hF;
		pin_in = '1;
		mask = '{`PFSM_P0_SEL_BITS, 8'hFF, 8'hFF, `PFSM_P3_SEL_BITS};
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (int k = 0; k < 4; k++) begin
			w = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : (k == 2) ? 8'h96 : 8'h69;
			if (k > 0) for (int p = 0; p < 4; p++) wr(16'(`PFSM_IDX_P0_SEL + p), w);
			repeat (2) @(posedge aclk);
			`CHK(t0_clk, ~w[6])
			for (int p = 0; p < 4; p++) begin
				rd(16'(`PFSM_IDX_P0_SEL + p));
				`CHK(rd_data, {24'h000000, w & mask[p]})
				`CHK(resp, `PFSM_RESP_OKAY)
				es = w & mask[p];
				pm = (p == 3) ? 8'h0F : 8'hFF;
				if (p == 3) es = es ^ `PFSM_P3_DBG_BITS;
				`CHK(pin_out[p] & pm, mx(es, 8'hA5, 8'h5A) & pm)
				`CHK(pin_oe[p] & pm, mx(es, 8'h0F, 8'hF0) & pm)
				`CHK(periph_in[p] & pm, es & pm)
				`CHK(gpio_in[p] & pm, ~es & pm)
			end
		end
		$display("test select done");
		rd(16'h5300);
		`CHK(resp, `PFSM_RESP_SLVERR)
		`CHK(rd_data, `PFSM_WORD_ZERO)
		wr(16'h5300, 8'hFF);
		`CHK(resp, `PFSM_RESP_SLVERR)
		$display("test unmapped done");
		wr(`PFSM_IDX_P0_FLAG, 8'hFF);
		`CHK(resp, `PFSM_RESP_OKAY)
		wr(`PFSM_IDX_P0_MASK, 8'h01);
		repeat (3) @(posedge aclk);
		`CHK(p0_irq, 1'b0)
		pin_in[0][0] <= 1'b0;
		repeat (4) @(posedge aclk);
		pin_in[0][0] <= 1'b1;
		repeat (4) @(posedge aclk);
		`CHK(p0_irq, 1'b1)
		wr(`PFSM_IDX_P0_FLAG, 8'h01);
		repeat (3) @(posedge aclk);
		`CHK(p0_irq, 1'b0)
		wr(`PFSM_IDX_P1_MASK, 8'h01);
		pin_in[1][0] <= 1'b0;
		repeat (4) @(posedge aclk);
		`CHK(p1_irq, 1'b1)
		wr(`PFSM_IDX_P1_FLAG, 8'h01);
		repeat (3) @(posedge aclk);
		`CHK(p1_irq, 1'b0)
		wr(`PFSM_IDX_P0_MASK, 8'h00);
		wr(`PFSM_IDX_P0_CHAT, 8'h01);
		wr(`PFSM_IDX_P0_FLAG, 8'hFF);
		wr(`PFSM_IDX_P0_MASK, 8'h01);
		// A 200-tick pulse is shorter than the 256-tick check time.
		pin_in[0][0] <= 1'b0;
		repeat (800) @(posedge aclk);
		pin_in[0][0] <= 1'b1;
		repeat (2100) @(posedge aclk);
		`CHK(p0_irq, 1'b0)
		pin_in[0][0] <= 1'b0;
		repeat (900) @(posedge aclk);
		`CHK(p0_irq, 1'b0)
		repeat (1200) @(posedge aclk);
		`CHK(p0_irq, 1'b1)
		$display("test filter done");
		// An edge that settles during sleep with the filter on must not raise a flag.
		wr(`PFSM_IDX_P0_FLAG, 8'h01);
		sleep_mode <= 1'b1;
		pin_in[0][0] <= 1'b1;
		repeat (1200) @(posedge aclk);
		`CHK(p0_irq, 1'b0)
		sleep_mode <= 1'b0;
		$display("test sleep done");
		for (int c = 0; c < 4; c++) begin
			wr(`PFSM_IDX_KRST, 8'(c));
			pin_in[0][3:0] <= 4'h0;
			repeat (3) @(posedge aclk);
			`CHK(krst_req, 1'(c != 0))
			sleep_mode <= 1'b1;
			repeat (3) @(posedge aclk);
			`CHK(krst_req, 1'b0)
			sleep_mode <= 1'b0;
			pin_in[0][3:0] <= 4'hC;
			repeat (3) @(posedge aclk);
			`CHK(krst_req, 1'(c == 1))
		end
		pin_in[0][3:0] <= 4'h0;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		`CHK(krst_req, 1'b0)
		wstrb <= 4'h0;
		wr(`PFSM_IDX_P1_SEL, 8'hFF);
		wstrb <= 4'hF;
		`CHK(resp, `PFSM_RESP_OKAY)
		rd(`PFSM_IDX_P1_SEL);
		`CHK(rd_data, `PFSM_WORD_ZERO)
		$display("test key reset done");
		results();
	end
endmodule : pfsm_tb_top
